// File: rtl/cell_port_pkg.sv
// cell_port_pkg: shared constants for the cell/nibble link port.
// assumes: one system clock and one link clock; no software registers.
package cell_port_pkg;
	localparam int unsigned OCTET_W = 8; // cell octet width
	localparam int unsigned NIBBLE_W = 4; // mii nibble width
	localparam logic [5:0] CELL_OCTETS = 6'h35; // 53 octets per cell
	localparam logic [5:0] LAST_OCTET = 6'h34; // index of final octet
	localparam logic [5:0] OCTET_ZERO = 6'h00; // first octet index
	localparam logic [7:0] IDLE_OCTET = 8'h00; // filler carried by idle cells
	localparam logic [1:0] MODE_UTOPIA_MASTER = 2'h0; // utopia master
	localparam logic [1:0] MODE_UTOPIA_SLAVE = 2'h1; // utopia slave
	localparam logic [1:0] MODE_MII = 2'h2; // ethernet nibble mode
	// cell transfer states
	typedef enum logic [1:0] {
		CELL_IDLE,
		CELL_MOVE
	} cell_state_t;
endpackage

// File: rtl/utopia_mii_cell_port.sv
// utopia_mii_cell_port: pin handshake of the cell / nibble link port.
// assumes: link pins and user octet streams live on link_clk_i; status outputs on clock_i; cells are
// handed over one octet per link cycle by a user source that honours ready.
// Behaviour
// R1: master raises receive enable to sample next cycle
// R2: external master raises receive enable as slave
// R3: receive data driven only after enable cycles
// R4: slave marks first receive octet with start-of-cell
// R5: slave raises receive cell available when cell ready
// R6: phy raises cell available input when cell ready
// R7: transmit enable held while sending frame nibbles
// R8: carrier without valid flags broken packet header
// R9: receive error tagged to current received data
// R10: eight-bit transmit octets, bit seven most significant
// R11: idle cells sent when no payload waiting
// R12: every cell transfer is fifty-three octets
// R13: four-bit transmit nibbles, bit three most significant
// R14: master transmit enable while valid octets driven
// R15: master start-of-cell on first transmit octet
// R16: cell transfer begins only after cell available
// R17: octet counter restarts at cell start, ends transfer
module utopia_mii_cell_port (
	// system side
	input wire logic clock_i,
	input wire logic rst_n_i,
	// link clock domain
	input wire logic link_clk_i,
	input wire logic link_rst_n_i,
	// static mode select (held stable while running)
	input wire logic [1:0] mode_i,
	// user transmit octet stream (link domain, handshake per octet)
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	// user receive octet stream (link domain)
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_first_o,
	output logic rx_err_o,
	// slave-side receive cell supply: a full cell waits in user logic
	input wire logic slave_cell_ready_i,
	input wire logic [7:0] slave_octet_i,
	output logic slave_octet_take_o,
	// utopia / mii pins, link domain
	output logic [7:0] txd_o,
	output logic tx_enb_o,
	output logic tx_soc_o,
	input wire logic tx_clav_i,
	output logic rx_enb_o,
	output logic rx_enb_oe_o,
	input wire logic rx_enb_i,
	input wire logic [7:0] rxd_i,
	output logic [7:0] rxd_o,
	output logic rxd_oe_o,
	input wire logic rx_soc_i,
	output logic rx_soc_o,
	input wire logic rx_clav_i,
	output logic rx_clav_o,
	output logic rx_clav_oe_o,
	input wire logic rx_dv_i,
	input wire logic rx_er_i,
	input wire logic crs_i,
	// system-domain status, synchronised
	output logic broken_header_o,
	output logic link_active_o
);
	////////////////////////////////////////////////////////////////////////
	// helpers

	// next octet index with wrap at the final octet
	function automatic logic [5:0] next_octet(input logic [5:0] idx);
		next_octet = (idx == cell_port_pkg::LAST_OCTET) ? cell_port_pkg::OCTET_ZERO : idx + 6'h01;
	endfunction

	// mode decode
	wire is_master = (mode_i == cell_port_pkg::MODE_UTOPIA_MASTER);
	wire is_slave = (mode_i == cell_port_pkg::MODE_UTOPIA_SLAVE);
	wire is_mii = (mode_i == cell_port_pkg::MODE_MII);

	////////////////////////////////////////////////////////////////////////
	// transmit path (link domain)

	cell_port_pkg::cell_state_t tx_state_r, tx_state_nxt;
	logic [5:0] tx_idx_r; // octet index within the current cell
	logic tx_idle_cell_r; // current cell is a filler cell
	logic [7:0] txd_r;
	logic tx_enb_r;
	logic tx_soc_r;
	logic tx_clav_s1_r, tx_clav_s2_r; // pin synchroniser

	// user octet is consumed on each cell octet of a user cell
	wire tx_cell_start = (tx_state_r == cell_port_pkg::CELL_IDLE) && tx_clav_s2_r; // [R16]
	wire tx_octet_go = (tx_state_r == cell_port_pkg::CELL_MOVE);
	wire tx_take = is_mii ? tx_valid_i : (tx_octet_go && !tx_idle_cell_r);
	// a filler cell starts whenever no user octet waits at cell start
	wire tx_start_idle = !tx_valid_i; // [R11]
	wire [7:0] tx_octet = (tx_octet_go && tx_idle_cell_r) ? cell_port_pkg::IDLE_OCTET : tx_data_i;
	// nibble lanes carry the low half, bit 3 most significant
	wire [7:0] tx_nibble = {4'h0, tx_data_i[cell_port_pkg::NIBBLE_W-1:0]}; // [R13]

	// state decode for the cell transmitter
	always_comb begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			cell_port_pkg::CELL_IDLE: begin
				if (!is_mii && tx_cell_start) begin
					tx_state_nxt = cell_port_pkg::CELL_MOVE;
				end
			end
			cell_port_pkg::CELL_MOVE: begin
				// ends after the 53rd octet
				if (tx_idx_r == cell_port_pkg::LAST_OCTET) begin // [R12] [R17]
					tx_state_nxt = cell_port_pkg::CELL_IDLE;
				end
			end
			default: tx_state_nxt = cell_port_pkg::CELL_IDLE;
		endcase
	end

	// cell state, index and filler flag
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			tx_state_r <= cell_port_pkg::CELL_IDLE;
			tx_idx_r <= cell_port_pkg::OCTET_ZERO;
			tx_idle_cell_r <= 1'b0;
		end else begin
			tx_state_r <= tx_state_nxt;
			if (tx_state_r == cell_port_pkg::CELL_IDLE) begin
				tx_idx_r <= cell_port_pkg::OCTET_ZERO; // [R17]
				tx_idle_cell_r <= tx_start_idle; // [R11]
			end else begin
				tx_idx_r <= next_octet(tx_idx_r); // [R17]
			end
		end
	end

	// pin registers: data, enable, start of cell
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			txd_r <= cell_port_pkg::IDLE_OCTET;
			tx_enb_r <= 1'b0;
			tx_soc_r <= 1'b0;
			tx_clav_s1_r <= 1'b0;
			tx_clav_s2_r <= 1'b0;
		end else begin
			tx_clav_s1_r <= tx_clav_i;
			tx_clav_s2_r <= tx_clav_s1_r;
			if (is_mii) begin
				txd_r <= tx_nibble; // [R13]
				tx_enb_r <= tx_valid_i; // mii enable held while nibbles flow [R7]
				tx_soc_r <= 1'b0;
			end else begin
				txd_r <= tx_octet; // bit 7 msb on the octet bus [R10]
				tx_enb_r <= is_master && tx_octet_go; // [R14]
				tx_soc_r <= is_master && tx_octet_go && (tx_idx_r == cell_port_pkg::OCTET_ZERO); // [R15]
			end
		end
	end

	assign txd_o = txd_r;
	assign tx_enb_o = tx_enb_r;
	assign tx_soc_o = tx_soc_r;

	// ready is a register copy one cycle early would break the handshake,
	// so it is combinational: from registered state in cell modes, from tx_valid_i in mii mode
	assign tx_ready_o = tx_take;

	////////////////////////////////////////////////////////////////////////
	// receive path, master and mii (link domain)

	logic [7:0] rxd_s1_r, rxd_s2_r; // data synchroniser
	logic rx_soc_s1_r, rx_soc_s2_r;
	logic rx_clav_s1_r, rx_clav_s2_r;
	logic rx_enb_s1_r, rx_enb_s2_r;
	logic rx_dv_s1_r, rx_dv_s2_r;
	logic rx_er_s1_r, rx_er_s2_r;
	logic crs_s1_r, crs_s2_r;
	cell_port_pkg::cell_state_t rx_state_r;
	logic [5:0] rx_idx_r;
	logic rx_enb_r; // our receive enable in master mode
	logic rx_sample_r; // sample one cycle after enable
	logic rx_sample_d1_r, rx_sample_d2_r; // sample flag delayed to meet the synchronised data
	logic is_master_r; // registered direction of the enable pin
	logic rx_valid_r, rx_first_r, rx_err_r;
	logic [7:0] rx_data_r;
	logic broken_r; // broken header seen, link domain

	// pin synchronisers: every input passes two flops
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			{rxd_s1_r, rxd_s2_r} <= 16'h0000;
			{rx_soc_s1_r, rx_soc_s2_r, rx_clav_s1_r, rx_clav_s2_r} <= 4'h0;
			{rx_enb_s1_r, rx_enb_s2_r, rx_dv_s1_r, rx_dv_s2_r} <= 4'h0;
			{rx_er_s1_r, rx_er_s2_r, crs_s1_r, crs_s2_r} <= 4'h0;
		end else begin
			rxd_s1_r <= rxd_i;
			rxd_s2_r <= rxd_s1_r;
			{rx_soc_s1_r, rx_soc_s2_r} <= {rx_soc_i, rx_soc_s1_r};
			{rx_clav_s1_r, rx_clav_s2_r} <= {rx_clav_i, rx_clav_s1_r};
			{rx_enb_s1_r, rx_enb_s2_r} <= {rx_enb_i, rx_enb_s1_r};
			{rx_dv_s1_r, rx_dv_s2_r} <= {rx_dv_i, rx_dv_s1_r};
			{rx_er_s1_r, rx_er_s2_r} <= {rx_er_i, rx_er_s1_r};
			{crs_s1_r, crs_s2_r} <= {crs_i, crs_s1_r};
		end
	end

	// master pulls a cell once the phy reports one available
	wire rx_master_start = is_master && (rx_state_r == cell_port_pkg::CELL_IDLE) && rx_clav_s2_r; // [R6]
	wire rx_master_busy = is_master && (rx_state_r == cell_port_pkg::CELL_MOVE);

	// receive cell state and enable
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			rx_state_r <= cell_port_pkg::CELL_IDLE;
			rx_idx_r <= cell_port_pkg::OCTET_ZERO;
			rx_enb_r <= 1'b0;
			rx_sample_r <= 1'b0;
			rx_sample_d1_r <= 1'b0;
			rx_sample_d2_r <= 1'b0;
		end else begin
			rx_sample_r <= rx_enb_r; // pin data stands the cycle after enable [R1] [R3]
			// two more stages: the pin data also passes two synchroniser flops
			rx_sample_d1_r <= rx_sample_r;
			rx_sample_d2_r <= rx_sample_d1_r;
			if (rx_master_start) begin
				rx_state_r <= cell_port_pkg::CELL_MOVE;
				rx_idx_r <= cell_port_pkg::OCTET_ZERO; // [R17]
				rx_enb_r <= 1'b1; // [R1]
			end else if (rx_master_busy) begin
				rx_idx_r <= next_octet(rx_idx_r);
				if (rx_idx_r == cell_port_pkg::LAST_OCTET) begin // [R12] [R17]
					rx_state_r <= cell_port_pkg::CELL_IDLE;
					rx_enb_r <= 1'b0;
				end
			end else begin
				rx_enb_r <= 1'b0;
				rx_state_r <= cell_port_pkg::CELL_IDLE;
			end
		end
	end

	// receive octet capture; error tagged onto the nibble it came with
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			rx_valid_r <= 1'b0;
			rx_first_r <= 1'b0;
			rx_err_r <= 1'b0;
			rx_data_r <= 8'h00;
			broken_r <= 1'b0;
		end else begin
			rx_data_r <= rxd_s2_r;
			if (is_mii) begin
				rx_valid_r <= rx_dv_s2_r;
				rx_first_r <= 1'b0;
				rx_err_r <= rx_dv_s2_r && rx_er_s2_r; // [R9]
				broken_r <= crs_s2_r && !rx_dv_s2_r; // [R8]
			end else begin
				rx_valid_r <= rx_sample_d2_r; // [R1]
				rx_first_r <= rx_sample_d2_r && rx_soc_s2_r; // [R1]
				rx_err_r <= 1'b0;
				broken_r <= 1'b0;
			end
		end
	end

	assign rx_valid_o = rx_valid_r;
	assign rx_first_o = rx_first_r;
	assign rx_err_o = rx_err_r;
	assign rx_data_o = rx_data_r;
	assign rx_enb_o = rx_enb_r;
	assign rx_enb_oe_o = is_master_r;

	////////////////////////////////////////////////////////////////////////
	// receive path, slave side: we supply cells to an external master

	logic rx_clav_oe_r; // clav pin owned while offering or sending
	logic slave_busy_r;
	logic [5:0] slave_idx_r;
	logic [7:0] rxd_out_r;
	logic rxd_oe_r, rx_soc_r, rx_clav_r, slave_take_r;

	// an octet leaves on each synchronised enable while a cell is in flight
	wire slave_step = is_slave && rx_enb_s2_r && (slave_busy_r || slave_cell_ready_i); // [R2]
	// a whole cell waits and none is in flight
	wire slave_offer = is_slave && slave_cell_ready_i && !slave_busy_r; // [R5]

	// slave supply: drive only in the cycle after a synchronised enable
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n_i) begin
			is_master_r <= 1'b0;
			slave_busy_r <= 1'b0;
			slave_idx_r <= cell_port_pkg::OCTET_ZERO;
			rxd_out_r <= 8'h00;
			{rxd_oe_r, rx_soc_r, rx_clav_r, slave_take_r} <= 4'h0;
			rx_clav_oe_r <= 1'b0;
		end else begin
			is_master_r <= is_master;
			rx_clav_r <= slave_offer; // [R5]
			rx_clav_oe_r <= slave_offer || slave_step; // registered so the pin enable is glitch free
			rxd_oe_r <= slave_step; // [R3]
			slave_take_r <= slave_step;
			rxd_out_r <= slave_octet_i;
			rx_soc_r <= slave_step && (slave_idx_r == cell_port_pkg::OCTET_ZERO); // [R4]
			if (slave_step) begin
				slave_idx_r <= next_octet(slave_idx_r); // [R17]
				slave_busy_r <= (slave_idx_r != cell_port_pkg::LAST_OCTET); // [R12]
			end
		end
	end

	assign rxd_o = rxd_out_r;
	assign rxd_oe_o = rxd_oe_r;
	assign rx_soc_o = rx_soc_r;
	assign rx_clav_o = rx_clav_r;
	assign rx_clav_oe_o = rx_clav_oe_r;
	assign slave_octet_take_o = slave_take_r;

	////////////////////////////////////////////////////////////////////////
	// status crossing into the system clock: levels, two flops each

	logic br_s1_r, br_s2_r, act_s1_r, act_s2_r;

	// level synchronisers toward clock_i
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			{br_s1_r, br_s2_r, act_s1_r, act_s2_r} <= 4'h0;
		end else begin
			br_s1_r <= broken_r;
			br_s2_r <= br_s1_r;
			act_s1_r <= tx_enb_r;
			act_s2_r <= act_s1_r;
		end
	end

	assign broken_header_o = br_s2_r;
	assign link_active_o = act_s2_r;
endmodule

// File: verif/utopia_mii_cell_port_assertions.sv
// cell_port_checker: link-side pin timing of the cell port.
// assumes: mode_i static while the link reset is released.
module cell_port_checker (
	// link domain
	input wire logic link_clk_i,
	input wire logic link_rst_n_i,
	input wire logic [1:0] mode_i,
	// transmit
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic [7:0] txd_o,
	input wire logic tx_enb_o,
	input wire logic tx_soc_o,
	input wire logic tx_clav_i,
	// receive
	input wire logic rx_enb_o,
	input wire logic rx_enb_i,
	input wire logic rxd_oe_o,
	input wire logic rx_valid_o,
	input wire logic rx_err_o,
	input wire logic rx_dv_i,
	input wire logic rx_er_i
);
	default clocking cb @(posedge link_clk_i); endclocking
	default disable iff (!link_rst_n_i);
	wire master_w = mode_i == cell_port_pkg::MODE_UTOPIA_MASTER; // mode decode
	wire slave_w = mode_i == cell_port_pkg::MODE_UTOPIA_SLAVE;
	wire mii_w = mode_i == cell_port_pkg::MODE_MII;
	wire [3:0] nib_w = tx_data_i[3:0]; // user nibble lane
	logic [5:0] tx_run_r; // enable run lengths; wrap only matters past a cell
	logic [5:0] rx_run_r;
	always_ff @(posedge link_clk_i) begin
		tx_run_r <= (link_rst_n_i && tx_enb_o) ? tx_run_r + 6'h01 : 6'h00;
		rx_run_r <= (link_rst_n_i && rx_enb_o) ? rx_run_r + 6'h01 : 6'h00;
	end
	// five quiet samples outlast the two-flop synchroniser
	sequence s_no_room;
		(master_w && !tx_clav_i) [*5];
	endsequence
	sequence s_bad_nibble;
		mii_w && rx_dv_i && rx_er_i;
	endsequence
	a_soc_opens_cell: assert property (master_w && $rose(tx_enb_o) |-> tx_soc_o)
		else $error("cell started without start of cell");
	a_soc_first_octet: assert property (master_w && tx_soc_o |-> tx_enb_o && tx_run_r == 6'h00)
		else $error("start of cell away from first octet");
	a_tx_cell_length: assert property (master_w && $fell(tx_enb_o) |-> tx_run_r == 6'h35)
		else $error("transmit cell not 53 octets");
	a_clav_gates_start: assert property (s_no_room |=> !$rose(tx_enb_o))
		else $error("cell started without cell available");
	a_rx_enable_length: assert property (master_w && $fell(rx_enb_o) |-> rx_run_r == 6'h35)
		else $error("receive enable run not 53 cycles");
	a_rx_sample_lag: assert property (master_w && rx_enb_o |-> ##4 rx_valid_o)
		else $error("enabled receive octet not sampled");
	a_rx_drive_after: assert property (slave_w && rxd_oe_o |-> $past(rx_enb_i, 3) || $past(rx_enb_i, 4))
		else $error("receive lines driven without enable");
	a_nibble_follows: assert property (mii_w && tx_valid_i |=> tx_enb_o && txd_o[3:0] == $past(nib_w))
		else $error("nibble not sent after strobe");
	a_err_tagged: assert property (s_bad_nibble |-> ##3 rx_err_o)
		else $error("receive error not reported");
endmodule
bind utopia_mii_cell_port cell_port_checker cell_port_checker_inst (.link_clk_i, .link_rst_n_i, .mode_i,
	.tx_valid_i, .tx_data_i, .txd_o, .tx_enb_o, .tx_soc_o, .tx_clav_i, .rx_enb_o, .rx_enb_i, .rxd_oe_o,
	.rx_valid_o, .rx_err_o, .rx_dv_i, .rx_er_i);

// File: verif/utopia_phy_model.sv
// utopia_phy_model: far-side phy for master mode; octet k of a cell is 0x40 + k.
// assumes: the bench grants cells through rx_have_i and room through tx_room_i.
module utopia_phy_model (
	input wire logic link_clk_i,
	input wire logic rx_have_i,
	input wire logic tx_room_i,
	input wire logic rx_enb_i,
	output logic tx_clav_o,
	output logic rx_clav_o,
	output logic [7:0] rxd_o,
	output logic rx_soc_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] idx = 6'h00; // octet index in cell
	logic run = 1'b0; // cell in progress
	logic en; // enable seen at the edge
	assign tx_clav_o = tx_room_i;
	assign rx_clav_o = rx_have_i && !run;
	initial begin
		rxd_o = 8'h00;
		rx_soc_o = 1'b0;
	end
	always @(posedge link_clk_i) begin
		en = rx_enb_i;
		#1;
		if (en) begin // drive only after an enable cycle
			rxd_o = {2'h0, idx} + 8'h40;
			rx_soc_o = idx == 6'h00;
			run = idx != 6'h34;
			idx = run ? idx + 6'h01 : 6'h00;
		end else begin // released: never a stale value
			rxd_o = ~rxd_o;
			rx_soc_o = ~rx_soc_o;
		end
	end
endmodule

// File: verif/test_utopia_mii_cell_port.sv
// test_utopia_mii_cell_port: scenario bench for the cell / nibble port.
// assumes: the phy model on the far side; mode changes only under reset.
module test_utopia_mii_cell_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 0, link_clk_i = 0, rst_n_i = 0, link_rst_n_i = 0;
	logic [1:0] mode_i = cell_port_pkg::MODE_UTOPIA_MASTER;
	logic tx_valid_i = 0, slave_cell_ready_i = 0, rx_dv_i = 0, rx_er_i = 0, crs_i = 0, tb_enb = 0;
	logic rx_have = 0, tx_room = 0, phy_soc, phy_clav, tx_clav_i;
	logic [7:0] tx_data_i = 8'h00, slave_octet_i = 8'h00, rx_data_o, txd_o, rxd_o, phy_rxd;
	logic tx_ready_o, rx_valid_o, rx_first_o, rx_err_o, slave_octet_take_o, tx_enb_o, tx_soc_o, rx_enb_o;
	logic rx_enb_oe_o, rxd_oe_o, rx_soc_o, rx_clav_o, rx_clav_oe_o, broken_header_o, link_active_o;
	int fails = 0, checked = 0;
	// pin level: the enabled party owns the pin
	wire rx_enb_i = rx_enb_oe_o ? rx_enb_o : tb_enb;
	wire rx_clav_i = rx_clav_oe_o ? rx_clav_o : phy_clav;
	wire [7:0] rxd_i = rxd_oe_o ? rxd_o : phy_rxd;
	wire rx_soc_i = rxd_oe_o ? rx_soc_o : phy_soc;
	always #2 clock_i = ~clock_i;
	always #62.5 link_clk_i = ~link_clk_i;
	utopia_mii_cell_port utopia_mii_cell_port_inst (.clock_i, .rst_n_i, .link_clk_i, .link_rst_n_i, .mode_i,
		.tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_first_o, .rx_err_o,
		.slave_cell_ready_i, .slave_octet_i, .slave_octet_take_o, .txd_o, .tx_enb_o, .tx_soc_o, .tx_clav_i,
		.rx_enb_o, .rx_enb_oe_o, .rx_enb_i, .rxd_i, .rxd_o, .rxd_oe_o, .rx_soc_i, .rx_soc_o, .rx_clav_i,
		.rx_clav_o, .rx_clav_oe_o, .rx_dv_i, .rx_er_i, .crs_i, .broken_header_o, .link_active_o);
	utopia_phy_model utopia_phy_model_inst (.link_clk_i, .rx_have_i(rx_have), .tx_room_i(tx_room),
		.rx_enb_i, .tx_clav_o(tx_clav_i), .rx_clav_o(phy_clav), .rxd_o(phy_rxd), .rx_soc_o(phy_soc));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic lstep();
		@(posedge link_clk_i);
		#1;
	endtask
	// both domains held low, then synchronisers given time to fill
	task automatic restart(input logic [1:0] mode);
		rst_n_i = 0;
		link_rst_n_i = 0;
		mode_i = mode;
		repeat (10) @(posedge clock_i);
		#1 rst_n_i = 1;
		repeat (2) lstep();
		link_rst_n_i = 1;
		repeat (4) lstep();
	endtask
	// master send: held off without room, one user cell, then idle cells
	task automatic master_tx();
		logic take;
		int n;
		int cells;
		n = 0;
		cells = 0;
		tx_valid_i = 1;
		tx_data_i = 8'h80;
		repeat (20) begin
			lstep();
			check(tx_enb_o, 0);
		end
		tx_room = 1;
		for (int c = 0; c < 200 && cells < 3; c++) begin
			take = tx_ready_o && tx_valid_i;
			lstep();
			if (take) begin
				tx_data_i = tx_data_i + 8'h01;
				tx_valid_i = tx_data_i != 8'hb5;
			end
			if (tx_soc_o) begin
				if (cells > 0) check(n, 53);
				cells++;
				n = 0;
			end
			if (tx_enb_o && n > 0) check(link_active_o, 1);
			if (tx_enb_o) begin
				check(txd_o, cells == 1 ? 32'h80 + n : cell_port_pkg::IDLE_OCTET);
				n++;
			end
		end
		check(cells, 3);
		if (cells < 3) print_verdict();
	endtask
	// master receive: one cell pulled from the phy model
	task automatic master_rx();
		int n;
		int firsts;
		logic [7:0] last;
		n = 0;
		firsts = 0;
		rx_have = 1;
		check(rx_enb_oe_o, 1);
		check(rxd_oe_o, 0);
		repeat (150) begin
			lstep();
			if (rx_enb_o) rx_have = 0;
			if (rx_valid_o) n++;
			if (rx_valid_o) last = rx_data_o;
			if (rx_first_o) firsts++;
			if (rx_first_o) check(rx_data_o, 8'h40);
		end
		check(n, 53);
		check(firsts, 1);
		check(last, 8'h74);
	endtask
	// slave receive: external master enables exactly one cell
	task automatic slave_rx();
		int takes;
		int socs;
		takes = 0;
		socs = 0;
		slave_cell_ready_i = 1;
		slave_octet_i = 8'h20;
		repeat (4) lstep();
		check(rx_clav_o, 1);
		check(rx_clav_oe_o, 1);
		check(rx_enb_oe_o, 0);
		for (int c = 0; c < 70; c++) begin
			tb_enb = c < 53;
			lstep();
			if (rx_soc_o) socs++;
			if (rx_soc_o) check(rxd_o, 8'h20);
			if (rx_soc_o) check(rxd_oe_o, 1);
			if (slave_octet_take_o) takes++;
			if (slave_octet_take_o) slave_cell_ready_i = 0;
			slave_octet_i = 8'h20 + 8'(takes);
		end
		check(takes, 53);
		check(socs, 1);
		check(rxd_oe_o, 0);
		check(rx_clav_oe_o, 0);
	endtask
	// nibble mode: transmit lane, receive error, carrier without valid
	task automatic mii_path();
		int waited;
		for (int i = 0; i < 5; i++) begin
			tx_valid_i = i < 4;
			tx_data_i = 8'ha0 + 8'(i);
			lstep();
			check(tx_enb_o, i < 4);
			if (i < 4) check(txd_o[3:0], i);
		end
		rx_dv_i = 1;
		rx_er_i = 1;
		lstep();
		rx_er_i = 0;
		repeat (2) lstep();
		check(rx_err_o, 1);
		lstep();
		check(rx_err_o, 0);
		check(rx_valid_o, 1);
		rx_dv_i = 0;
		crs_i = 1;
		waited = 0;
		while (broken_header_o !== 1'b1 && waited < 50) begin
			lstep();
			waited++;
		end
		check(broken_header_o, 1);
		if (waited == 50) print_verdict();
	endtask
	initial begin
		restart(cell_port_pkg::MODE_UTOPIA_MASTER);
		master_tx();
		tx_room = 0;
		tx_valid_i = 0;
		restart(cell_port_pkg::MODE_UTOPIA_MASTER);
		master_rx();
		restart(cell_port_pkg::MODE_UTOPIA_SLAVE);
		slave_rx();
		restart(cell_port_pkg::MODE_MII);
		mii_path();
		print_verdict();
	end
endmodule
